// file: ccr_cache_ctl.sv
// processor read control of a two-group cache with overlapped memory cycles
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module ccr_cache_ctl #(
	parameter int QD = 4,
	parameter logic [15:0] TOUT_INIT = ccr_pkg::TOUT_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_req,
	input wire logic cpu_abort,
	input wire logic cpu_confirm,
	input ccr_pkg::ccr_req_type cpu_xfer,
	input wire logic read_pause_write,
	input wire logic pending_map_request,
	input wire logic pending_fast_port_request,
	input wire logic fp_write,
	input wire logic [ccr_pkg::FP_IDW-1:0] fp_id,
	input ccr_pkg::ccr_req_type fp_xfer,
	input ccr_pkg::ccr_dword_type fp_wdata,
	input wire logic mem_ack,
	input wire logic mem_bus_data_occupied,
	input wire logic mem_rdv,
	input ccr_pkg::ccr_dword_type mem_rdata,
	input wire logic mem_bus_parity_fault,
	output logic cpu_port_cycle,
	output logic lock,
	output logic cpu_sync,
	output logic cpu_bus_error,
	output logic [ccr_pkg::WW-1:0] cpu_rdata,
	output logic mem_start,
	output ccr_pkg::ccr_req_type mem_xfer,
	output ccr_pkg::ccr_dword_type mem_wdata,
	output logic mem_wdata_oe,
	output logic timeout_enable_n,
	output logic fp_done,
	output logic [ccr_pkg::NFP-1:0] fp_rdv,
	output ccr_pkg::ccr_dword_type fp_rdata
);
	import ccr_pkg::*;

	localparam int QCW = $clog2(QD + 1);
	localparam int IW = IDX_HI - IDX_LO + 1;
	localparam int TW = TAG_HI - TAG_LO + 1;

	typedef struct packed {
		ccr_state_type fsm;
		logic hold;
		logic lock;
		logic cpc;
		logic slow;
		logic want;
		logic start;
		logic wr;
		logic wdoe;
		logic lcpu;
		logic conf;
		logic abt;
		logic gack;
		logic grdv;
		logic tenb_n;
		logic sync;
		logic err;
		logic fpdone;
		logic hit;
		logic perr;
		logic terr;
		logic pready;
		logic pslverr;
		logic [FP_IDW-1:0] lid;
		logic [TMR_W-1:0] tmr;
		logic [DSK_W-1:0] dsk;
		logic [15:0] tout;
		logic [15:0] tlim;
		ccr_req_type req;
		ccr_dword_type wdata;
		ccr_dword_type bdr;
		ccr_dword_type fprd;
		logic [WW-1:0] rdata;
		logic [NFP-1:0] fprdv;
		ccr_qent_type [QD-1:0] q;
		logic [QCW-1:0] qcnt;
		logic [1:0][NIDX-1:0] valid;
		logic [NIDX-1:0] repl;
		logic [31:0] prdata;
	} ccr_st_type;

	ccr_st_type st;
	ccr_st_type n;
	ccr_dword_type dmem0 [NIDX];
	ccr_dword_type dmem1 [NIDX];
	logic [TW-1:0] tmem0 [NIDX];
	logic [TW-1:0] tmem1 [NIDX];
	logic [IW-1:0] idx;
	logic [TW-1:0] tag;
	logic hit0;
	logic hit1;

	function automatic logic [WW-1:0] word_sel(ccr_dword_type d, logic odd);
		return odd ? d.hi : d.lo;
	endfunction

	// group match on index and tag
	assign idx = st.req.addr[IDX_HI:IDX_LO];
	assign tag = st.req.addr[TAG_HI:TAG_LO];
	assign hit0 = st.valid[0][idx] && (tmem0[idx] == tag);
	assign hit1 = st.valid[1][idx] && (tmem1[idx] == tag);

	always_comb begin
		logic pop;
		logic push;
		logic [QCW-1:0] qi;
		n = st;
		pop = mem_rdv && (st.qcnt != '0);
		push = mem_ack && st.start && !st.wr;
		qi = '0;
		n.sync = 1'b0;
		n.err = 1'b0;
		n.fpdone = 1'b0;
		n.fprdv = '0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		// held request, set wins over abort
		n.hold = (st.hold && !cpu_abort) || cpu_req;
		if (mem_bus_parity_fault) begin
			n.perr = 1'b1;
		end
		// register bus: answer in the first access cycle
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.prdata = '0;
			if (paddr == REG_CTRL) begin
				n.prdata[15:0] = st.tlim;
			end else if (paddr == REG_STAT) begin
				n.prdata[STAT_TERR] = st.terr;
				n.prdata[STAT_PERR] = st.perr;
				n.prdata[STAT_LOCK] = st.lock;
				n.prdata[STAT_SLOW] = st.slow;
				n.prdata[STAT_HIT] = st.hit;
				n.prdata[STAT_FSM +: 3] = st.fsm;
			end else begin
				n.pslverr = 1'b1;
			end
		end
		if (psel && penable && st.pready && pwrite) begin
			if (paddr == REG_CTRL) begin
				n.tlim = pwdata[15:0];
			end else if (paddr == REG_STAT) begin
				if (pwdata[STAT_TERR]) begin
					n.terr = 1'b0;
				end
				if (pwdata[STAT_PERR] && !mem_bus_parity_fault) begin
					n.perr = 1'b0;
				end
			end
		end
		// acknowledge ends the start request
		if (mem_ack) begin
			n.start = 1'b0;
		end
		// bus launch: wait ack low, deskew address or data, then start
		if (st.want) begin
			if (mem_ack || st.start || (!st.wr && st.qcnt == QCW'(QD))) begin
				n.dsk = '0;
			end else if (st.wr && !st.wdoe) begin
				n.dsk = '0;
				if (!mem_bus_data_occupied) begin
					n.wdoe = 1'b1;
				end
			end else if (st.dsk == (st.wr ? DSK_DAT_LAST : DSK_ADR_LAST)) begin
				n.start = 1'b1;
				n.want = 1'b0;
				n.dsk = '0;
			end else begin
				n.dsk = st.dsk + 1'b1;
			end
		end
		// outstanding reads, oldest first
		if (pop) begin
			if (st.q[0].is_cpu) begin
				n.bdr = mem_rdata;
				n.grdv = 1'b1;
			end else begin
				n.fprdv[st.q[0].id] = 1'b1;
				n.fprd = mem_rdata;
			end
			for (int i = 0; i < QD - 1; i++) begin
				n.q[i] = st.q[i + 1];
			end
		end
		if (push) begin
			qi = st.qcnt - QCW'(pop);
			n.q[qi].is_cpu = st.lcpu;
			n.q[qi].id = st.lid;
		end
		n.qcnt = st.qcnt + QCW'(push) - QCW'(pop);
		unique case (st.fsm)
			S_IDLE: begin
				if (pending_fast_port_request && !read_pause_write) begin
					n.fsm = S_FP;
					n.lock = 1'b1;
					n.req = fp_xfer;
					n.wr = fp_write;
					n.wdata = fp_wdata;
					n.lcpu = 1'b0;
					n.lid = fp_id;
					n.want = 1'b1;
					n.wdoe = 1'b0;
					n.dsk = '0;
				end else if ((cpu_req || st.hold) && !read_pause_write
					&& !pending_map_request && !pending_fast_port_request) begin
					n.fsm = S_CPU;
					n.lock = 1'b1;
					n.cpc = 1'b1;
					n.req = cpu_xfer;
					n.wr = 1'b0;
					n.lcpu = 1'b1;
					n.tmr = '0;
					n.conf = 1'b0;
					n.abt = 1'b0;
					n.gack = 1'b0;
					n.grdv = 1'b0;
				end
			end
			S_CPU: begin
				n.conf = st.conf || cpu_confirm;
				n.abt = st.abt || cpu_abort;
				if (st.tmr != T180_LAST) begin
					n.tmr = st.tmr + 1'b1;
				end else if (st.abt) begin
					n.fsm = S_IDLE;
					n.lock = 1'b0;
					n.cpc = 1'b0;
				end else if (st.conf) begin
					n.hold = cpu_req;
					n.hit = hit0 || hit1;
					if (hit0 || hit1) begin
						n.sync = 1'b1;
						n.rdata = word_sel(hit1 ? dmem1[idx] : dmem0[idx],
							st.req.addr[WSEL]);
						n.fsm = S_IDLE;
						n.lock = 1'b0;
						n.cpc = 1'b0;
					end else begin
						n.fsm = S_SLOW;
						n.slow = 1'b1;
						n.want = 1'b1;
						n.dsk = '0;
						n.tout = '0;
						n.tenb_n = 1'b0;
					end
				end
			end
			S_SLOW: begin
				if (mem_ack && st.start) begin
					n.gack = 1'b1;
				end
				if (st.gack && st.grdv) begin
					n.tenb_n = 1'b1;
					n.fsm = S_FILL;
				end else if (st.tout >= st.tlim) begin
					n.terr = 1'b1;
					n.err = 1'b1;
					n.sync = 1'b1;
					n.tenb_n = 1'b1;
					n.want = 1'b0;
					n.start = 1'b0;
					n.slow = 1'b0;
					n.fsm = S_IDLE;
					n.lock = 1'b0;
					n.cpc = 1'b0;
				end else begin
					n.tout = st.tout + 1'b1;
				end
			end
			S_FILL: begin
				// data mux takes the bus word, never the store
				n.rdata = word_sel(st.bdr, st.req.addr[WSEL]);
				n.sync = 1'b1;
				n.valid[st.repl[idx]][idx] = 1'b1;
				n.repl[idx] = !st.repl[idx];
				n.slow = 1'b0;
				n.fsm = S_IDLE;
				n.lock = 1'b0;
				n.cpc = 1'b0;
			end
			S_FP: begin
				if (mem_ack && st.start) begin
					n.fpdone = 1'b1;
					n.wdoe = 1'b0;
					n.fsm = S_IDLE;
					n.lock = 1'b0;
				end
			end
			default: begin
				n.fsm = S_IDLE;
				n.lock = 1'b0;
				n.cpc = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.tlim <= TOUT_INIT;
			st.tenb_n <= 1'b1;
		end else begin
			st <= n;
		end
	end

	// refill of one group with both words and the tag
	always_ff @(posedge pclk) begin
		if (st.fsm == S_FILL) begin
			if (st.repl[idx]) begin
				dmem1[idx] <= st.bdr;
				tmem1[idx] <= tag;
			end else begin
				dmem0[idx] <= st.bdr;
				tmem0[idx] <= tag;
			end
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign cpu_port_cycle = st.cpc;
	assign lock = st.lock;
	assign cpu_sync = st.sync;
	assign cpu_bus_error = st.err;
	assign cpu_rdata = st.rdata;
	assign mem_start = st.start;
	assign mem_xfer = st.req;
	assign mem_wdata = st.wdata;
	assign mem_wdata_oe = st.wdoe;
	assign timeout_enable_n = st.tenb_n;
	assign fp_done = st.fpdone;
	assign fp_rdv = st.fprdv;
	assign fp_rdata = st.fprd;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence cpu_enter;
		st.fsm == S_IDLE && n.fsm == S_CPU;
	endsequence
	sequence hit_at_t180;
		st.fsm == S_CPU && st.tmr == T180_LAST && !st.abt && st.conf && (hit0 || hit1);
	endsequence

	a_ack_drop_start: assert property (mem_ack && st.start |=> !st.start)
		else $error("start not cleared by acknowledge");
	a_cycle_gate: assert property (cpu_enter |-> !read_pause_write
		&& !pending_map_request && !pending_fast_port_request && (cpu_req || st.hold))
		else $error("processor cycle started while blocked");
	a_cycle_lock: assert property (cpu_enter |=> cpu_port_cycle && lock)
		else $error("cycle entry without cycle and lock");
	a_lock_excl: assert property (lock |=> !(st.fsm == S_FP && $past(st.fsm) != S_FP)
		&& !(cpu_port_cycle && !$past(cpu_port_cycle)))
		else $error("locked cycle interrupted");
	a_addr_bus: assert property (cpu_enter |=> mem_xfer == $past(cpu_xfer))
		else $error("processor address not placed on memory bus");
	a_hit_sync: assert property (hit_at_t180 |=> cpu_sync && !lock && !cpu_port_cycle)
		else $error("hit did not complete at T180");
	a_hit_word: assert property ((hit_at_t180 and (hit0 && !hit1)) |=> cpu_rdata
		== word_sel($past(dmem0[idx]), $past(st.req.addr[WSEL])))
		else $error("wrong hit word returned");
	a_slow_deskew: assert property ($rose(st.slow) |-> !mem_start [*8])
		else $error("start raised before address deskew");
	a_write_free: assert property ($rose(st.wdoe) |-> $past(!mem_bus_data_occupied))
		else $error("write data driven while bus occupied");
	a_rdv_steer: assert property (mem_rdv && st.qcnt != '0 && !st.q[0].is_cpu
		|=> fp_rdv == (NFP'(1) << $past(st.q[0].id)))
		else $error("data valid steered to wrong port");
	a_tout_inhibit: assert property (st.fsm == S_SLOW && st.gack && st.grdv
		|=> timeout_enable_n ##1 cpu_sync && !lock)
		else $error("timeout not inhibited or miss not completed");
	a_miss_word: assert property (st.fsm == S_FILL
		|=> cpu_rdata == word_sel($past(st.bdr), $past(st.req.addr[WSEL])))
		else $error("miss returned wrong bus word");
	a_tout_flag: assert property (st.fsm == S_SLOW && !(st.gack && st.grdv)
		&& st.tout >= st.tlim |=> cpu_bus_error && !lock)
		else $error("bus timeout not flagged");
endmodule

// file: ccr_mem_model.sv
// main memory partner answering the cache bus cycles
`timescale 1ns/1ps
module ccr_mem_model (
	input wire logic pclk,
	input wire logic mem_start,
	input ccr_pkg::ccr_req_type mem_xfer,
	input wire logic skip,
	input wire logic [7:0] lat,
	output logic mem_ack,
	output logic mem_bus_data_occupied,
	output logic mem_rdv,
	output ccr_pkg::ccr_dword_type mem_rdata
);
	import ccr_pkg::*;
	logic [AW-1:0] aq[$];
	int tq[$];
	int now = 0;
	logic [17:0] b;
	initial begin
		mem_ack = 1'b0;
		mem_bus_data_occupied = 1'b0;
		mem_rdv = 1'b0;
		mem_rdata = '0;
	end
	always @(posedge pclk) begin
		now <= now + 1;
		mem_ack <= mem_start && !mem_ack && !skip;
		// cycle_type_hi marks a write here: no data comes back
		if (mem_start && !mem_ack && !skip && !mem_xfer.cycle_type_hi) begin
			aq.push_back(mem_xfer.addr);
			tq.push_back(now + int'(lat));
		end
		mem_rdv <= 1'b0;
		// released data lines wander
		mem_rdata <= ~mem_rdata;
		mem_bus_data_occupied <= tq.size() != 0;
		if (tq.size() != 0 && tq[0] == now) begin
			b = {aq[0][17:2], 2'b00};
			mem_rdv <= 1'b1;
			mem_rdata <= {b ^ 18'h2AAAA, b};
			void'(aq.pop_front());
			void'(tq.pop_front());
		end
	end
endmodule

// file: ccr_pkg.sv
// constants and carrier types for the cache processor-read controller
package ccr_pkg;
	localparam int CLK_NS = 8;
	localparam int T180_NS = 180;
	localparam int T180_CYC = (T180_NS + CLK_NS - 1) / CLK_NS;
	localparam int DESKEW_NS = 100;
	localparam int DESKEW_CYC = (DESKEW_NS + CLK_NS - 1) / CLK_NS;
	localparam int DDESKEW_NS = 50;
	localparam int DDESKEW_CYC = (DDESKEW_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = $clog2(T180_CYC + 1);
	localparam int DSK_W = $clog2(DESKEW_CYC + 1);
	localparam logic [TMR_W-1:0] T180_LAST = TMR_W'(T180_CYC - 1);
	localparam logic [DSK_W-1:0] DSK_ADR_LAST = DSK_W'(DESKEW_CYC - 1);
	localparam logic [DSK_W-1:0] DSK_DAT_LAST = DSK_W'(DDESKEW_CYC - 1);
	localparam logic [15:0] TOUT_DEF = 16'h0100;
	localparam int AW = 22;
	localparam int WW = 18;
	localparam int IDX_HI = 9;
	localparam int IDX_LO = 2;
	localparam int TAG_HI = 21;
	localparam int TAG_LO = 10;
	localparam int WSEL = 1;
	localparam int NIDX = 1 << (IDX_HI - IDX_LO + 1);
	localparam int FP_IDW = 2;
	localparam int NFP = 1 << FP_IDW;
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STAT = 12'h004;
	localparam int STAT_TERR = 0;
	localparam int STAT_PERR = 1;
	localparam int STAT_LOCK = 2;
	localparam int STAT_SLOW = 3;
	localparam int STAT_HIT = 4;
	localparam int STAT_FSM = 8;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CPU = 3'b001,
		S_SLOW = 3'b010,
		S_FILL = 3'b011,
		S_FP = 3'b100
	} ccr_state_type;
	typedef struct packed {
		logic [AW-1:0] addr;
		logic cycle_type_hi;
		logic cycle_type_lo;
	} ccr_req_type;
	typedef struct packed {
		logic [WW-1:0] hi;
		logic [WW-1:0] lo;
	} ccr_dword_type;
	typedef struct packed {
		logic is_cpu;
		logic [FP_IDW-1:0] id;
	} ccr_qent_type;
endpackage

// file: testbench.sv
// self-checking bench for the cache processor-read controller
`timescale 1ns/1ps
module testbench;
	import ccr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic cpu_req, cpu_abort, cpu_confirm, read_pause_write, pending_map_request;
	logic pending_fast_port_request, fp_write, mem_ack, mem_bus_data_occupied, mem_rdv;
	logic mem_bus_parity_fault, cpu_port_cycle, lock, cpu_sync, cpu_bus_error, mem_start;
	logic mem_wdata_oe, timeout_enable_n, fp_done, mem_skip;
	logic [FP_IDW-1:0] fp_id;
	logic [NFP-1:0] fp_rdv;
	logic [WW-1:0] cpu_rdata, d;
	logic [7:0] mem_lat;
	ccr_req_type cpu_xfer, fp_xfer, mem_xfer;
	ccr_dword_type fp_wdata, mem_rdata, mem_wdata, fp_rdata;
	int n_fail = 0, n_compared = 0, cyc = 0, nrdv = 0, n, ns, nst, nsy = 0;
	logic [39:0] rlog[4];
	logic [21:0] fa;
	localparam logic [21:0] A1 = 22'h12346;
	logic [21:0] ha[6] = '{A1, A1, A1 ^ 22'h2, A1 + 22'h400, A1, A1 + 22'h400};
	bit hm[6] = '{0, 1, 1, 0, 1, 1};

	ccr_cache_ctl #(.QD(4), .TOUT_INIT(16'h0040)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cpu_req, .cpu_abort, .cpu_confirm, .cpu_xfer, .read_pause_write,
		.pending_map_request, .pending_fast_port_request, .fp_write, .fp_id, .fp_xfer,
		.fp_wdata, .mem_ack, .mem_bus_data_occupied, .mem_rdv, .mem_rdata,
		.mem_bus_parity_fault, .cpu_port_cycle, .lock, .cpu_sync, .cpu_bus_error, .cpu_rdata,
		.mem_start, .mem_xfer, .mem_wdata, .mem_wdata_oe, .timeout_enable_n, .fp_done,
		.fp_rdv, .fp_rdata
	);
	ccr_mem_model mem_i (
		.pclk, .mem_start, .mem_xfer, .skip(mem_skip), .lat(mem_lat), .mem_ack,
		.mem_bus_data_occupied, .mem_rdv, .mem_rdata
	);

	function automatic logic [17:0] ew(input logic [21:0] a);
		return {a[17:2], 2'b00} ^ (a[1] ? 18'h2AAAA : 18'h0);
	endfunction
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// ns: first cycle of slow state, nst: first bus start
	task automatic cpu_rd(input logic [21:0] a, input bit go, output logic [17:0] dd,
		output logic ee, output int nn, output int s, output int st);
		cpu_xfer <= '{a, 1'b0, 1'b0};
		cpu_req <= go;
		nn = 0;
		s = 0;
		st = 0;
		@(posedge pclk);
		cpu_req <= 1'b0;
		do begin
			@(posedge pclk);
			nn++;
			cpu_confirm <= (nn == 1);
			if (timeout_enable_n === 1'b0 && s == 0) s = nn;
			if (mem_start === 1'b1 && st == 0) st = nn;
			if (nn == 1 && go) chk({lock, cpu_port_cycle, mem_xfer.addr}, {2'b11, a});
		end while (cpu_sync !== 1'b1);
		dd = cpu_rdata;
		ee = cpu_bus_error;
		chk({lock, timeout_enable_n}, 2'b01);
	endtask

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cpu_sync === 1'b1) nsy <= nsy + 1;
		if (fp_rdv !== '0) begin
			rlog[nrdv & 3] <= {fp_rdv, fp_rdata};
			nrdv <= nrdv + 1;
		end
		if (cyc == 6000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cpu_req, cpu_abort} = '0;
		{cpu_confirm, read_pause_write, pending_map_request, pending_fast_port_request} = '0;
		{fp_write, fp_id, mem_skip, mem_bus_parity_fault} = '0;
		cpu_xfer = '0;
		fp_xfer = '0;
		fp_wdata = '0;
		mem_lat = 8'h18;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({lock, mem_start, timeout_enable_n, fp_rdv}, 7'h10);
		apb(1'b0, REG_CTRL, 32'h0, r);
		chk(r, 32'h40);
		apb(1'b1, REG_CTRL, 32'h50, r);
		apb(1'b0, REG_CTRL, 32'h0, r);
		chk(r, 32'h50);
		apb(1'b0, 12'h008, 32'h0, r);
		chk({perr, r}, 33'h1_0000_0000);
		mem_bus_parity_fault <= 1'b1;
		@(posedge pclk);
		mem_bus_parity_fault <= 1'b0;
		apb(1'b0, REG_STAT, 32'h0, r);
		chk(r & 32'h70F, 32'h2);
		apb(1'b1, REG_STAT, 32'h2, r);
		apb(1'b0, REG_STAT, 32'h0, r);
		chk(r & 32'h70F, 32'h0);
		foreach (ha[i]) begin
			cpu_rd(ha[i], 1'b1, d, e, n, ns, nst);
			chk({e, d}, {1'b0, ew(ha[i])});
			if (hm[i]) chk(40'(n), 40'(T180_CYC + 1));
			else chk({20'(ns), 20'(nst - ns)}, {20'(T180_CYC + 1), 20'(DESKEW_CYC)});
		end
		pending_map_request <= 1'b1;
		cpu_req <= 1'b1;
		@(posedge pclk);
		cpu_req <= 1'b0;
		cpu_abort <= 1'b1;
		@(posedge pclk);
		cpu_abort <= 1'b0;
		pending_map_request <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(lock, 1'b0);
		n = nsy;
		cpu_req <= 1'b1;
		@(posedge pclk);
		cpu_req <= 1'b0;
		@(posedge pclk);
		chk(lock, 1'b1);
		cpu_abort <= 1'b1;
		@(posedge pclk);
		cpu_abort <= 1'b0;
		repeat (T180_CYC) @(posedge pclk);
		chk({lock, 8'(nsy - n)}, 9'h0);
		for (int k = 0; k < 2; k++) begin
			pending_map_request <= (k == 0);
			read_pause_write <= (k == 1);
			cpu_req <= 1'b1;
			@(posedge pclk);
			cpu_req <= 1'b0;
			repeat (4) @(posedge pclk);
			chk(lock, 1'b0);
			pending_map_request <= 1'b0;
			read_pause_write <= 1'b0;
			repeat (3) @(posedge pclk);
			chk({lock, cpu_port_cycle}, 2'b11);
			cpu_rd(cpu_xfer.addr, 1'b0, d, e, n, ns, nst);
			chk(d, ew(cpu_xfer.addr));
		end
		fp_wdata <= 36'h5A5A53C3C;
		for (int k = 1; k < 4; k++) begin
			fp_id <= FP_IDW'(k);
			fp_write <= (k == 3);
			fp_xfer.cycle_type_hi <= (k == 3);
			fp_xfer.addr <= A1 + 22'(k * 2048);
			pending_fast_port_request <= 1'b1;
			do @(posedge pclk); while (lock !== 1'b1);
			pending_fast_port_request <= 1'b0;
			if (k == 3) begin
				do @(posedge pclk); while (mem_wdata_oe !== 1'b1);
				chk({mem_bus_data_occupied, mem_start, 4'(nrdv)}, 6'h2);
			end
			do @(posedge pclk); while (fp_done !== 1'b1);
			if (k == 2) chk(40'(nrdv), 40'h0);
		end
		chk(mem_wdata, 36'h5A5A53C3C);
		for (int k = 1; k < 3; k++) begin
			fa = A1 + 22'(k * 2048);
			chk(rlog[k - 1], {NFP'(1 << k), ew(fa | 22'h2), ew(fa & ~22'h2)});
		end
		mem_skip <= 1'b1;
		cpu_rd(A1 + 22'h1000, 1'b1, d, e, n, ns, nst);
		chk(e, 1'b1);
		apb(1'b0, REG_STAT, 32'h0, r);
		chk(r[STAT_TERR], 1'b1);
		apb(1'b1, REG_STAT, 32'h1, r);
		apb(1'b0, REG_STAT, 32'h0, r);
		chk(r[STAT_TERR], 1'b0);
		end_of_test();
	end
endmodule
